// ==== verilog/adc_conversion_sequencer.v ====
// conversion sequencer: start, sample, compare, end processing, result
// How it works
// - no sample-hold: 49 cycles at 8 bit, 59 at 10 bit
// - with sample-hold: 28 cycles at 8 bit, 33 at 10 bit
// - one-shot completion shows on irq flag and start flag
// - clearing start flag mid conversion aborts, result keeps its previous value
// - 1024 codes at 10 bit, 256 codes at 8 bit
// - channel select takes effect only with input group enabled
// - auto start: timer request while start flag set; else start write
`timescale 1ns/1ps
`include "adc_seq_regs.vh"
module adc_conversion_sequencer #(
    parameter DIV = `ADC_CLK_DIV,
    parameter RES_W = 10
) (
    // clock and reset
    input wire CORE_CLK_IN,
    input wire RST_IN,
    // control bits from software
    input wire START_SET_IN,
    input wire START_CLR_IN,
    input wire AUTO_START_SELECT_IN,
    input wire TIMER_CAPTURE_IRQ_IN,
    input wire OPERATING_MODE_SELECT_IN,
    input wire RES10_SELECT_IN,
    input wire SAMPLE_HOLD_ENABLE_IN,
    input wire REFERENCE_CONNECT_IN,
    input wire INPUT_GROUP_ENABLE_IN,
    input wire [2:0] CHANNEL_SELECT_IN,
    input wire CHANNEL_WRITE_IN,
    input wire IRQ_CLEAR_IN,
    // comparator from the analog side
    input wire COMPARATOR_IN,
    // analog side controls
    output reg SAMPLE_OUT,
    output reg [RES_W-1:0] DAC_CODE_OUT,
    output reg [2:0] CHANNEL_OUT,
    // status
    output reg CONVERSION_START_FLAG_OUT,
    output reg IRQ_REQUEST_FLAG_OUT,
    output reg BUSY_OUT,
    output reg REF_SETTLED_OUT,
    output reg [RES_W-1:0] RESULT_OUT
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SAMP1 = 3'h1;
    localparam ST_CMP = 3'h2;
    localparam ST_SAMPN = 3'h3;
    localparam ST_END = 3'h4;
    localparam ST_ARM = 3'h5;
    localparam [15:0] SETTLE = `VREF_SETTLE_CYC;

    reg [7:0] div_r;
    reg half_r;
    reg [2:0] state_r;
    reg [7:0] cnt_r;
    reg [3:0] bits_left_r;
    reg sh_r;
    reg res10_r;
    reg repeat_r;
    reg [15:0] settle_r;
    reg ref_prev_r;
    reg first_r;
    reg sar_load_r;
    reg sar_decide_r;
    wire [RES_W-1:0] sar_code;
    wire [RES_W-1:0] sar_trial;
    wire [3:0] nbits = RES10_SELECT_IN ? `RES_BITS_HI : `RES_BITS_LO;
    wire abort = START_CLR_IN && state_r != ST_IDLE;

    adc_sar_step #(.WIDTH(RES_W)) sar (
        .clk_in(CORE_CLK_IN),
        .rst_in(RST_IN),
        .load_in(sar_load_r),
        .nbits_in(nbits),
        .decide_in(sar_decide_r),
        .comp_in(COMPARATOR_IN),
        .code_out(sar_code),
        .trial_out(sar_trial)
    );

    // half converter-clock enable; counts are in half cycles so 2.5 is exact
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN || state_r == ST_IDLE) begin
            div_r <= 8'h00;
            half_r <= 1'b0;
        end else if (div_r == (DIV[7:0] >> 1) - 8'h1) begin
            div_r <= 8'h00;
            half_r <= 1'b1;
        end else begin
            div_r <= div_r + 8'h1;
            half_r <= 1'b0;
        end
    end

    // reference settling status, informs software of its wait
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            ref_prev_r <= 1'b0;
            settle_r <= 16'h0000;
            REF_SETTLED_OUT <= 1'b0;
        end else begin
            ref_prev_r <= REFERENCE_CONNECT_IN;
            if (!REFERENCE_CONNECT_IN) begin
                settle_r <= 16'h0000;
                REF_SETTLED_OUT <= 1'b0;
            end else if (!ref_prev_r) begin
                settle_r <= 16'h0001;
                REF_SETTLED_OUT <= 1'b0;
            end else if (settle_r < SETTLE) begin
                settle_r <= settle_r + 16'h0001;
            end else begin
                REF_SETTLED_OUT <= 1'b1;
            end
        end
    end

    // channel latch, only honoured with the input group enabled
    always @(posedge CORE_CLK_IN) begin
        if (RST_IN)
            CHANNEL_OUT <= `CHANNEL_RESET;
        else if (CHANNEL_WRITE_IN && INPUT_GROUP_ENABLE_IN)
            CHANNEL_OUT <= CHANNEL_SELECT_IN;
    end

    // main sequencer; configuration is captured at start so later writes
    // cannot change the timing of a running conversion
    always @(posedge CORE_CLK_IN) begin
        sar_load_r <= 1'b0;
        sar_decide_r <= 1'b0;
        if (RST_IN) begin
            state_r <= ST_IDLE;
            cnt_r <= 8'h00;
            bits_left_r <= 4'h0;
            sh_r <= 1'b0;
            res10_r <= 1'b0;
            repeat_r <= 1'b0;
            first_r <= 1'b0;
            CONVERSION_START_FLAG_OUT <= 1'b0;
            IRQ_REQUEST_FLAG_OUT <= 1'b0;
            BUSY_OUT <= 1'b0;
            SAMPLE_OUT <= 1'b0;
            DAC_CODE_OUT <= `RESULT_RESET;
            RESULT_OUT <= `RESULT_RESET;
        end else begin
            if (IRQ_CLEAR_IN)
                IRQ_REQUEST_FLAG_OUT <= 1'b0;
            if (START_SET_IN)
                CONVERSION_START_FLAG_OUT <= 1'b1;
            else if (START_CLR_IN)
                CONVERSION_START_FLAG_OUT <= 1'b0;
            DAC_CODE_OUT <= sar_code | sar_trial;
            if (abort) begin
                state_r <= ST_IDLE;
                BUSY_OUT <= 1'b0;
                SAMPLE_OUT <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        if ((!AUTO_START_SELECT_IN && START_SET_IN) ||
                            (AUTO_START_SELECT_IN && CONVERSION_START_FLAG_OUT &&
                             TIMER_CAPTURE_IRQ_IN)) begin
                            sh_r <= SAMPLE_HOLD_ENABLE_IN;
                            res10_r <= RES10_SELECT_IN;
                            repeat_r <= OPERATING_MODE_SELECT_IN;
                            state_r <= ST_ARM;
                            BUSY_OUT <= 1'b1;
                        end
                    end
                    ST_ARM: begin
                        sar_load_r <= 1'b1;
                        bits_left_r <= res10_r ? `RES_BITS_HI : `RES_BITS_LO;
                        first_r <= 1'b1;
                        SAMPLE_OUT <= 1'b1;
                        cnt_r <= `NSH_SAMPLE1; // equal in both modes
                        state_r <= ST_SAMP1;
                    end
                    ST_SAMP1, ST_SAMPN: if (half_r) begin
                        if (cnt_r <= 8'h01) begin
                            SAMPLE_OUT <= 1'b0;
                            cnt_r <= sh_r ? (first_r ? `SH_COMPARE1 : `SH_COMPARE_N)
                                          : (first_r ? `NSH_COMPARE1 : `NSH_COMPARE_N);
                            state_r <= ST_CMP;
                        end else
                            cnt_r <= cnt_r - 8'h01;
                    end
                    ST_CMP: if (half_r) begin
                        if (cnt_r == 8'h01) begin
                            sar_decide_r <= 1'b1;
                            first_r <= 1'b0;
                            bits_left_r <= bits_left_r - 4'h1;
                            if (bits_left_r == 4'h1) begin
                                cnt_r <= sh_r ? `SH_END : `NSH_END;
                                state_r <= ST_END;
                            end else if (sh_r) begin
                                cnt_r <= `SH_COMPARE_N;
                            end else begin
                                cnt_r <= `NSH_SAMPLE_N;
                                SAMPLE_OUT <= 1'b1;
                                state_r <= ST_SAMPN;
                            end
                        end else
                            cnt_r <= cnt_r - 8'h01;
                    end
                    ST_END: if (half_r) begin
                        if (cnt_r == 8'h01) begin
                            RESULT_OUT <= sar_code;
                            if (repeat_r) begin
                                state_r <= ST_ARM;
                            end else begin
                                state_r <= ST_IDLE;
                                BUSY_OUT <= 1'b0;
                                if (!START_SET_IN)
                                    CONVERSION_START_FLAG_OUT <= 1'b0;
                                IRQ_REQUEST_FLAG_OUT <= 1'b1;
                            end
                        end else
                            cnt_r <= cnt_r - 8'h01;
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ==== verilog/adc_seq_regs.vh ====
// timing counts, result widths and reset values for the conversion sequencer
`ifndef ADC_SEQ_REGS_VH
`define ADC_SEQ_REGS_VH

// converter clock divider default (core clocks per converter clock)
`define ADC_CLK_DIV 8'h19

// half-cycle counts, without sample-and-hold
`define NSH_SAMPLE1 8'h08
`define NSH_COMPARE1 8'h04
`define NSH_SAMPLE_N 8'h05
`define NSH_COMPARE_N 8'h05
`define NSH_END 8'h10

// half-cycle counts, with sample-and-hold
`define SH_SAMPLE1 8'h08
`define SH_COMPARE1 8'h05
`define SH_SAMPLE_N 8'h00
`define SH_COMPARE_N 8'h05
`define SH_END 8'h08

// result widths
`define RES_BITS_HI 4'hA
`define RES_BITS_LO 4'h8

// reference settling count: one microsecond of 4 ns core clocks
`define VREF_SETTLE_CYC 16'h00FA

// control field reset values
`define CHANNEL_RESET 3'h4
`define RESULT_RESET 10'h000

`endif

// ==== verilog/adc_sar_step.v ====
// successive-approximation register: one comparison decision per pulse
`timescale 1ns/1ps
module adc_sar_step #(
    parameter WIDTH = 10
) (
    input wire clk_in,
    input wire rst_in,
    input wire load_in,
    input wire [3:0] nbits_in,
    input wire decide_in,
    input wire comp_in,
    output reg [WIDTH-1:0] code_out,
    output reg [WIDTH-1:0] trial_out
);
    // trial bit walks from msb of the selected width down to bit 0
    always @(posedge clk_in) begin
        if (rst_in) begin
            code_out <= {WIDTH{1'b0}};
            trial_out <= {WIDTH{1'b0}};
        end else if (load_in) begin
            code_out <= {WIDTH{1'b0}};
            trial_out <= {{(WIDTH-1){1'b0}}, 1'b1} << (nbits_in - 4'h1);
        end else if (decide_in) begin
            if (comp_in)
                code_out <= code_out | trial_out; // keep bit: input at or above trial
            trial_out <= trial_out >> 1;
        end
    end
endmodule

// ==== dv/analog_sensor.sv ====
// behavioural analog sensor answering the comparator from the trial code
`timescale 1ns/1ps
module analog_sensor (
    input wire [9:0] level_in,
    input wire res10_in,
    input wire [9:0] code_in,
    output wire comp_out
);
    // 8-bit trials see the top eight bits of the level, so ties keep the bit
    wire [9:0] scaled = res10_in ? level_in : {2'h0, level_in[9:2]};
    assign comp_out = (scaled >= code_in);
endmodule

// ==== dv/adc_seq_properties.sv ====
// port-level assertions for the conversion sequencer
`timescale 1ns/1ps
module adc_seq_properties #(
    parameter DIV = 25,
    parameter RES_W = 10
) (
    input wire CORE_CLK_IN, RST_IN, START_SET_IN, START_CLR_IN, AUTO_START_SELECT_IN,
    input wire TIMER_CAPTURE_IRQ_IN, OPERATING_MODE_SELECT_IN, RES10_SELECT_IN,
    input wire SAMPLE_HOLD_ENABLE_IN, INPUT_GROUP_ENABLE_IN, CHANNEL_WRITE_IN,
    input wire IRQ_CLEAR_IN, CONVERSION_START_FLAG_OUT, IRQ_REQUEST_FLAG_OUT, BUSY_OUT,
    input wire [2:0] CHANNEL_SELECT_IN,
    input wire [2:0] CHANNEL_OUT,
    input wire [RES_W-1:0] RESULT_OUT
);
    localparam int HC = DIV / 2;
    logic [11:0] len_r;
    wire [7:0] halves = SAMPLE_HOLD_ENABLE_IN ? (RES10_SELECT_IN ? 8'h42 : 8'h38)
        : (RES10_SELECT_IN ? 8'h76 : 8'h62);
    wire [11:0] nominal = 12'(halves * HC);
    // busy length; repeat mode is skipped since it never drops between passes
    always @(posedge CORE_CLK_IN)
        len_r <= (RST_IN || !BUSY_OUT || OPERATING_MODE_SELECT_IN) ? 12'h000 : len_r + 12'h001;
    default clocking @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);
    sw_start_a: assert property (START_SET_IN && !AUTO_START_SELECT_IN && !START_CLR_IN
        && !BUSY_OUT |=> BUSY_OUT) else $error("software start ignored");
    no_start_a: assert property (!BUSY_OUT && !OPERATING_MODE_SELECT_IN && !TIMER_CAPTURE_IRQ_IN
        && (AUTO_START_SELECT_IN || !(START_SET_IN || CONVERSION_START_FLAG_OUT)) |=> !BUSY_OUT)
        else $error("conversion began without trigger");
    done_flags_a: assert property ($rose(IRQ_REQUEST_FLAG_OUT) && !$past(START_SET_IN)
        |-> $past(BUSY_OUT) && !BUSY_OUT && !CONVERSION_START_FLAG_OUT)
        else $error("completion flags inconsistent");
    abort_clean_a: assert property (BUSY_OUT && START_CLR_IN
        |=> !BUSY_OUT && $stable(RESULT_OUT) && !$rose(IRQ_REQUEST_FLAG_OUT))
        else $error("abort misbehaved");
    chan_refuse_a: assert property (CHANNEL_WRITE_IN && !INPUT_GROUP_ENABLE_IN
        |=> $stable(CHANNEL_OUT)) else $error("channel taken while group disabled");
    chan_take_a: assert property (CHANNEL_WRITE_IN && INPUT_GROUP_ENABLE_IN
        |=> CHANNEL_OUT == $past(CHANNEL_SELECT_IN)) else $error("channel write lost");
    conv_len_a: assert property ($fell(BUSY_OUT) && !$past(START_CLR_IN)
        && !OPERATING_MODE_SELECT_IN |-> len_r + 12'h001 >= nominal && len_r <= nominal + 12'h004)
        else $error("conversion length wrong");
    irq_hold_a: assert property (IRQ_REQUEST_FLAG_OUT && !IRQ_CLEAR_IN
        |=> IRQ_REQUEST_FLAG_OUT) else $error("request flag dropped");
    low_range_a: assert property ($rose(IRQ_REQUEST_FLAG_OUT) && !RES10_SELECT_IN
        |-> RESULT_OUT[RES_W-1:8] == 0) else $error("8-bit result out of range");
    cover property ($rose(IRQ_REQUEST_FLAG_OUT));
    cover property (BUSY_OUT && START_CLR_IN);
    cover property (AUTO_START_SELECT_IN && TIMER_CAPTURE_IRQ_IN && !BUSY_OUT);
endmodule
bind adc_conversion_sequencer adc_seq_properties #(.DIV(DIV), .RES_W(RES_W)) i_props (.*);

// ==== dv/tb_top.sv ====
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_top;
    logic CORE_CLK_IN, RST_IN, START_SET_IN, START_CLR_IN, AUTO_START_SELECT_IN;
    logic TIMER_CAPTURE_IRQ_IN, OPERATING_MODE_SELECT_IN, RES10_SELECT_IN, IRQ_CLEAR_IN;
    logic SAMPLE_HOLD_ENABLE_IN, REFERENCE_CONNECT_IN, INPUT_GROUP_ENABLE_IN, CHANNEL_WRITE_IN;
    logic [2:0] CHANNEL_SELECT_IN;
    logic [9:0] level;
    wire COMPARATOR_IN, SAMPLE_OUT, CONVERSION_START_FLAG_OUT, IRQ_REQUEST_FLAG_OUT;
    wire BUSY_OUT, REF_SETTLED_OUT;
    wire [9:0] DAC_CODE_OUT, RESULT_OUT;
    wire [2:0] CHANNEL_OUT;
    int mismatches = 0, checks = 0, cyc = 0;
    // rows: sample-hold, 10 bit, level, expected result
    logic [21:0] rows [4] = '{{1'b0, 1'b0, 10'h3FF, 10'h0FF}, {1'b0, 1'b1, 10'h2A5, 10'h2A5},
        {1'b1, 1'b0, 10'h155, 10'h055}, {1'b1, 1'b1, 10'h001, 10'h001}};
    // short converter clock keeps the run brief: half cycle of 2 core clocks
    adc_conversion_sequencer #(.DIV(4)) i_dut (.*);
    analog_sensor i_sensor (.level_in(level), .res10_in(RES10_SELECT_IN),
        .code_in(DAC_CODE_OUT), .comp_out(COMPARATOR_IN));
    initial begin
        CORE_CLK_IN = 1'b0;
        forever #2 CORE_CLK_IN = ~CORE_CLK_IN;
    end
    // hang guard, well above the expected run length
    always @(posedge CORE_CLK_IN) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            $display("ERROR %0t timeout", $time);
            test_done;
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic ck(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CORE_CLK_IN);
    endtask
    task automatic start;
        @(posedge CORE_CLK_IN) START_SET_IN <= 1'b1;
        @(posedge CORE_CLK_IN) START_SET_IN <= 1'b0;
    endtask
    // bounded wait for the end of a conversion
    task automatic wait_idle;
        int n;
        n = 0;
        // look 1 ns after each edge so the flop outputs have settled
        @(posedge CORE_CLK_IN) #1;
        while (BUSY_OUT !== 1'b0 && n < 400) begin
            @(posedge CORE_CLK_IN) #1;
            n++;
        end
        ck(n < 400, "busy stuck");
    endtask
    task automatic run(input logic [21:0] r);
        @(posedge CORE_CLK_IN) {SAMPLE_HOLD_ENABLE_IN, RES10_SELECT_IN, level} <= r[21:10];
        start;
        @(posedge CORE_CLK_IN) #1 ck(SAMPLE_OUT === 1'b1 && BUSY_OUT === 1'b1, "sampling");
        wait_idle;
        ck(RESULT_OUT === r[9:0], "result");
        ck(IRQ_REQUEST_FLAG_OUT === 1'b1 && CONVERSION_START_FLAG_OUT === 1'b0
            && SAMPLE_OUT === 1'b0, "done");
        @(posedge CORE_CLK_IN) IRQ_CLEAR_IN <= 1'b1;
        @(posedge CORE_CLK_IN) IRQ_CLEAR_IN <= 1'b0;
        #1 ck(IRQ_REQUEST_FLAG_OUT === 1'b0, "irq clear");
    endtask
    initial begin
        {START_SET_IN, START_CLR_IN, AUTO_START_SELECT_IN, TIMER_CAPTURE_IRQ_IN} = 4'h0;
        {OPERATING_MODE_SELECT_IN, RES10_SELECT_IN, IRQ_CLEAR_IN, CHANNEL_WRITE_IN} = 4'h0;
        {SAMPLE_HOLD_ENABLE_IN, REFERENCE_CONNECT_IN, INPUT_GROUP_ENABLE_IN} = 3'h0;
        CHANNEL_SELECT_IN = 3'h0;
        level = 10'h000;
        RST_IN = 1'b1;
        tick(2);
        RST_IN <= 1'b0;
        tick(1);
        #1 ck(CHANNEL_OUT === 3'h4 && RESULT_OUT === 10'h000 && BUSY_OUT === 1'b0, "reset");
        ck({SAMPLE_OUT, CONVERSION_START_FLAG_OUT, IRQ_REQUEST_FLAG_OUT, REF_SETTLED_OUT} === 4'h0
            && DAC_CODE_OUT === 10'h000, "reset flags");
        // group enable first, then the channel write
        @(posedge CORE_CLK_IN) {INPUT_GROUP_ENABLE_IN, REFERENCE_CONNECT_IN} <= 2'h3;
        CHANNEL_SELECT_IN <= 3'h5;
        @(posedge CORE_CLK_IN) CHANNEL_WRITE_IN <= 1'b1;
        @(posedge CORE_CLK_IN) {INPUT_GROUP_ENABLE_IN, CHANNEL_SELECT_IN} <= 4'h6;
        @(posedge CORE_CLK_IN) {INPUT_GROUP_ENABLE_IN, CHANNEL_WRITE_IN} <= 2'h2;
        #1 ck(CHANNEL_OUT === 3'h5, "channel");
        ck(REF_SETTLED_OUT === 1'b0, "reference early");
        tick(250);
        #1 ck(REF_SETTLED_OUT === 1'b1, "reference settled");
        foreach (rows[i]) run(rows[i]);
        // abort keeps the old result and raises no request
        @(posedge CORE_CLK_IN) level <= 10'h123;
        start;
        tick(20);
        START_CLR_IN <= 1'b1;
        @(posedge CORE_CLK_IN) START_CLR_IN <= 1'b0;
        #1 ck(BUSY_OUT === 1'b0 && RESULT_OUT === 10'h001 && IRQ_REQUEST_FLAG_OUT === 1'b0,
            "abort");
        // automatic start waits for the timer request
        @(posedge CORE_CLK_IN) {AUTO_START_SELECT_IN, level} <= 11'h600;
        start;
        tick(5);
        #1 ck(BUSY_OUT === 1'b0 && CONVERSION_START_FLAG_OUT === 1'b1, "auto wait");
        @(posedge CORE_CLK_IN) TIMER_CAPTURE_IRQ_IN <= 1'b1;
        @(posedge CORE_CLK_IN) TIMER_CAPTURE_IRQ_IN <= 1'b0;
        #1 ck(BUSY_OUT === 1'b1, "auto start");
        wait_idle;
        ck(RESULT_OUT === 10'h200 && IRQ_REQUEST_FLAG_OUT === 1'b1, "auto result");
        // repeat mode at 8 bit, channel written again after the mode change
        @(posedge CORE_CLK_IN) {AUTO_START_SELECT_IN, OPERATING_MODE_SELECT_IN} <= 2'h1;
        {IRQ_CLEAR_IN, RES10_SELECT_IN, level} <= 12'h8C8;
        @(posedge CORE_CLK_IN) {IRQ_CLEAR_IN, CHANNEL_WRITE_IN} <= 2'h1;
        @(posedge CORE_CLK_IN) CHANNEL_WRITE_IN <= 1'b0;
        #1 ck(CHANNEL_OUT === 3'h6, "channel again");
        start;
        tick(300);
        #1 ck(RESULT_OUT === 10'h032 && IRQ_REQUEST_FLAG_OUT === 1'b0, "repeat");
        @(posedge CORE_CLK_IN) level <= 10'h3FC;
        tick(450);
        #1 ck(RESULT_OUT === 10'h0FF && CONVERSION_START_FLAG_OUT === 1'b1, "rearm");
        @(posedge CORE_CLK_IN) START_CLR_IN <= 1'b1;
        @(posedge CORE_CLK_IN) START_CLR_IN <= 1'b0;
        #1 ck(BUSY_OUT === 1'b0, "repeat stop");
        // reset in mid conversion returns the outputs to their idle values
        start;
        tick(10);
        RST_IN <= 1'b1;
        tick(2);
        RST_IN <= 1'b0;
        @(posedge CORE_CLK_IN) #1 ck(BUSY_OUT === 1'b0 && RESULT_OUT === 10'h000
            && CHANNEL_OUT === 3'h4 && CONVERSION_START_FLAG_OUT === 1'b0, "mid reset");
        test_done;
    end
endmodule
